// ---- hw/sram_host_pkg.sv ----
package sram_host_pkg;
    // memory organisation
    localparam int ADDR_WIDTH = 17;
    localparam int DATA_WIDTH = 24;
    // clock period in picoseconds
    localparam int CLK_PERIOD_PS = 5000;
    // timing figures in picoseconds (least and longest times both round up)
    localparam int ADDRESS_ACCESS_TIME_PS = 10000;
    localparam int OUTPUT_ENABLE_ACCESS_TIME_PS = 5000;
    localparam int ADDRESS_CHANGE_HOLD_PS = 3000;
    localparam int WRITE_DATA_SETUP_PS = 5500;
    localparam int STROBE_TO_FLOAT_TIME_PS = 5000;
    localparam int SELECT_TO_WRITE_END_PS = 7000;
    localparam int ADDRESS_TO_WRITE_END_PS = 7000;
    localparam int CYCLE_TIME_PS = 10000;
    localparam int DESELECT_TO_STANDBY_PS = 10000;
    // power-up wait in microseconds
    localparam int POWERUP_WAIT_US = 100;
    // derived cycle counts
    localparam int READ_WAIT_CYC = (ADDRESS_ACCESS_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int FLOAT_WAIT_CYC = (STROBE_TO_FLOAT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SETUP_CYC = (WRITE_DATA_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SEL_END_CYC = (SELECT_TO_WRITE_END_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYCLE_CYC = (CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int POWERUP_WAIT_CYC = POWERUP_WAIT_US * 1000000 / CLK_PERIOD_PS;
    // write pulse: float delay plus data setup, and never under select/address setup
    localparam int PULSE_CYC_RAW = FLOAT_WAIT_CYC + SETUP_CYC;
    localparam int WRITE_PULSE_CYC = (PULSE_CYC_RAW > SEL_END_CYC) ? PULSE_CYC_RAW : SEL_END_CYC;
    // data drive starts only after the memory has floated
    localparam int WRITE_DRIVE_CYC = FLOAT_WAIT_CYC;
    // counter width
    localparam int CNT_W = 16;
endpackage

// ---- hw/sram_host.sv ----
`timescale 1ns/1ps
// Functional notes
// - write only with all selects on, strobe low
// - data set up 5.5 ns before terminating edge
// - strobe stays high through every read
// - address valid no later than select activation
// - strobe pulse covers float delay plus setup
// - no data driven while memory still drives
// - wait 100 us before the first access
// - select 7 ns before end; cycles 10 ns apart
// - address 7 ns before end, valid at start
// - select active: a low, b high, c low
module sram_host
    import sram_host_pkg::*;
#(
    parameter int POWERUP_CYCLES = POWERUP_WAIT_CYC
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // user request side
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [ADDR_WIDTH-1:0] req_addr_i,
    input wire logic [DATA_WIDTH-1:0] req_wdata_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [DATA_WIDTH-1:0] rsp_rdata_o,
    output logic init_done_o,
    // memory pins
    output logic [ADDR_WIDTH-1:0] mem_addr_o,
    output logic chip_select_a_n_o,
    output logic chip_select_b_o,
    output logic chip_select_c_n_o,
    output logic output_enable_n_o,
    output logic write_enable_n_o,
    input wire logic [DATA_WIDTH-1:0] data_lines_i,
    output logic [DATA_WIDTH-1:0] data_lines_o,
    output logic data_lines_oe_o
);
    // refuse counts the counter cannot hold
    if (POWERUP_CYCLES < 1 || POWERUP_CYCLES >= (1 << CNT_W))
    begin : g_bad_param
        $error("powerup count out of range");
    end

    typedef enum {ST_POWERUP, ST_IDLE, ST_READ, ST_WRITE, ST_GAP} state_e;

    // all state in one struct
    typedef struct packed {
        state_e st;
        logic [CNT_W-1:0] cnt;
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] wdata;
        logic [DATA_WIDTH-1:0] rdata;
        logic rsp_valid;
        logic ready;
        logic init_done;
        logic sel;  // combined select active
        logic sel_n;  // inverted copy so the low-active pins leave a flop directly
        logic oe_n;
        logic we_n;
        logic drive;
    } state_s;

    state_s q, d;

    // no synchroniser on read data: the bus is sampled only after the access time,
    // when the memory holds it stable, so metastability is not expected there

    // next-state logic
    always_comb
    begin
        d = q;
        d.rsp_valid = 1'b0;
        case (q.st)
            // selects held off and strobe high until the wait ends
            ST_POWERUP:
            begin
                d.sel = 1'b0;
                d.we_n = 1'b1;
                if (q.cnt == CNT_W'(POWERUP_CYCLES - 1))
                begin
                    d.st = ST_IDLE;
                    d.cnt = '0;
                    d.ready = 1'b1;
                    d.init_done = 1'b1;
                end
                else
                begin
                    d.cnt = q.cnt + 1'b1;
                end
            end
            // take a request; address goes out with the select edge
            ST_IDLE:
            begin
                if (req_valid_i)
                begin
                    d.ready = 1'b0;
                    d.addr = req_addr_i;
                    d.wdata = req_wdata_i;
                    d.sel = 1'b1;
                    d.cnt = '0;
                    if (req_write_i)
                    begin
                        // output enable kept low: strobe-controlled write
                        d.st = ST_WRITE;
                        d.we_n = 1'b0;
                        d.oe_n = 1'b0;
                    end
                    else
                    begin
                        d.st = ST_READ;
                        d.we_n = 1'b1;
                        d.oe_n = 1'b0;
                    end
                end
            end
            // wait the full access time, then capture
            ST_READ:
            begin
                if (q.cnt == CNT_W'(READ_WAIT_CYC - 1))
                begin
                    d.rdata = data_lines_i;
                    d.rsp_valid = 1'b1;
                    d.sel = 1'b0;
                    d.oe_n = 1'b1;
                    d.st = ST_GAP;
                    d.cnt = '0;
                end
                else
                begin
                    d.cnt = q.cnt + 1'b1;
                end
            end
            // hold the strobe low for float plus setup; drive only after float
            ST_WRITE:
            begin
                if (q.cnt == CNT_W'(WRITE_DRIVE_CYC - 1))
                begin
                    d.drive = 1'b1;
                end
                if (q.cnt == CNT_W'(WRITE_PULSE_CYC - 1))
                begin
                    // strobe ends the write; selects and data stay one more cycle for hold
                    d.we_n = 1'b1;
                    d.oe_n = 1'b1;
                    d.st = ST_GAP;
                    d.cnt = '0;
                end
                else
                begin
                    d.cnt = q.cnt + 1'b1;
                end
            end
            // release selects and bus, keep the cycle spacing
            ST_GAP:
            begin
                d.sel = 1'b0;
                d.drive = 1'b0;
                if (q.cnt == CNT_W'(CYCLE_CYC - 1))
                begin
                    d.st = ST_IDLE;
                    d.ready = 1'b1;
                    d.cnt = '0;
                end
                else
                begin
                    d.cnt = q.cnt + 1'b1;
                end
            end
            default:
            begin
                d.st = ST_POWERUP;
            end
        endcase
        // low-active selects track the combined select in the same edge
        d.sel_n = ~d.sel;
    end

    // state register
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q <= '{st: ST_POWERUP, oe_n: 1'b1, we_n: 1'b1, sel_n: 1'b1, default: '0};
        end
        else
        begin
            q <= d;
        end
    end

    // outputs straight from flops; combined select encoding
    assign chip_select_a_n_o = q.sel_n;
    assign chip_select_b_o = q.sel;
    assign chip_select_c_n_o = q.sel_n;
    assign mem_addr_o = q.addr;
    assign output_enable_n_o = q.oe_n;
    assign write_enable_n_o = q.we_n;
    assign data_lines_o = q.wdata;
    assign data_lines_oe_o = q.drive;
    assign req_ready_o = q.ready;
    assign rsp_valid_o = q.rsp_valid;
    assign rsp_rdata_o = q.rdata;
    assign init_done_o = q.init_done;

    // assertions
    chk_no_early_access: assert property (@(posedge clk_i) disable iff (rst_i)
        !q.init_done |-> (chip_select_b_o == 1'b0 && write_enable_n_o == 1'b1))
        else $error("access before power-up wait");
    chk_read_strobe_high: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.st == ST_READ) |-> write_enable_n_o)
        else $error("strobe low during read");
    chk_write_needs_sel: assert property (@(posedge clk_i) disable iff (rst_i)
        !write_enable_n_o |-> chip_select_b_o && !chip_select_a_n_o && !chip_select_c_n_o)
        else $error("strobe low without select");
    chk_pulse_width: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(write_enable_n_o) |-> !write_enable_n_o [*3])
        else $error("write pulse too short");
    chk_no_drive_early: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(write_enable_n_o) |-> !data_lines_oe_o)
        else $error("data driven before float");
    chk_data_setup: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(write_enable_n_o) |-> $past(data_lines_oe_o, 2) && $past(data_lines_oe_o))
        else $error("data setup short");
    chk_addr_stable: assert property (@(posedge clk_i) disable iff (rst_i)
        chip_select_b_o && $past(chip_select_b_o) |-> $stable(mem_addr_o))
        else $error("address moved in cycle");
    chk_cycle_gap: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(chip_select_b_o) |-> !chip_select_b_o [*2])
        else $error("cycle spacing short");
    chk_read_done: assert property (@(posedge clk_i) disable iff (rst_i)
        // capture happens two edges after the take; the pulse is seen one edge later
        (q.st == ST_IDLE && req_valid_i && !req_write_i) |-> ##3 rsp_valid_o)
        else $error("read answer late");
    cov_read: cover property (@(posedge clk_i) rsp_valid_o);
    cov_write: cover property (@(posedge clk_i) $rose(write_enable_n_o));
    cov_init: cover property (@(posedge clk_i) $rose(init_done_o));
endmodule

// ---- verification/sram_mem_model.sv ----
`timescale 1ns/1ps
module sram_mem_model
    import sram_host_pkg::*;
(
    // memory pins from the controller
    input wire logic [ADDR_WIDTH-1:0] addr_i,
    input wire logic sel_a_n_i,
    input wire logic sel_b_i,
    input wire logic sel_c_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic [DATA_WIDTH-1:0] bus_i,
    // answer speed select
    input wire logic slow_i,
    // drive back onto the shared bus
    output logic [DATA_WIDTH-1:0] data_o,
    output logic drive_o,
    output logic standby_o
);
    // sparse store, only written words exist
    logic [DATA_WIDTH-1:0] store [logic [ADDR_WIDTH-1:0]];
    logic sel;
    logic wr;
    logic rd;
    assign sel = !sel_a_n_i && sel_b_i && !sel_c_n_i;
    assign wr = sel && !we_n_i;
    // outputs only with enable low and strobe high, so a joint release stays floated
    assign rd = sel && !oe_n_i && we_n_i;
    initial
    begin
        data_o = '0;
        drive_o = 1'b0;
        standby_o = 1'b1;
    end
    // word lands when the overlap closes, whichever pin ends it first
    always @(negedge wr)
        if (!$isunknown(addr_i))
            store[addr_i] = bus_i;
    // old word holds until the new one arrives; slow mode uses most of the budget
    always @(rd or addr_i)
        if (rd)
        begin
            data_o <= #(slow_i ? 9 : 4) store[addr_i];
            drive_o <= #1 1'b1;
        end
        else
            drive_o <= #1 1'b0;
    // low-power state follows deselect, wakes at once on select
    always @(sel)
        standby_o <= #(sel ? 0 : 10) !sel;
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
    import sram_host_pkg::*;
    localparam int PU = 10;
    // rows: write flag, address, data (expected data for reads)
    localparam logic [41:0] ROWS [8] = '{{1'b1, 17'h00000, 24'hA5A5A5},
        {1'b1, 17'h1FFFF, 24'h5A5A5A}, {1'b1, 17'h0FFFF, 24'hFFFFFF},
        {1'b0, 17'h1FFFF, 24'h5A5A5A}, {1'b0, 17'h00000, 24'hA5A5A5},
        {1'b0, 17'h0FFFF, 24'hFFFFFF}, {1'b1, 17'h1FFFF, 24'h000001},
        {1'b0, 17'h1FFFF, 24'h000001}};
    // user side stimulus
    logic clk_i = 0;
    logic rst_i = 1;
    logic req_valid_i = 0;
    logic req_write_i = 0;
    logic [ADDR_WIDTH-1:0] req_addr_i = '0;
    logic [DATA_WIDTH-1:0] req_wdata_i = '0;
    logic slow = 0;
    // design outputs and bus
    logic req_ready_o, rsp_valid_o, init_done_o, mem_drive, standby;
    logic chip_select_a_n_o, chip_select_b_o, chip_select_c_n_o;
    logic output_enable_n_o, write_enable_n_o, data_lines_oe_o;
    logic [ADDR_WIDTH-1:0] mem_addr_o;
    logic [DATA_WIDTH-1:0] rsp_rdata_o, data_lines_o, mem_data, last_bus = '0;
    wire logic [DATA_WIDTH-1:0] data_lines_i;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    // no pull on the bus: a floated bus shows the inverse of its last level
    assign data_lines_i = data_lines_oe_o ? data_lines_o : mem_drive ? mem_data : ~last_bus;
    always @(data_lines_i)
        if (data_lines_oe_o || mem_drive)
            last_bus = data_lines_i;
    sram_host #(.POWERUP_CYCLES(PU)) sram_host_i (.clk_i, .rst_i, .req_valid_i, .req_write_i,
        .req_addr_i, .req_wdata_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .init_done_o,
        .mem_addr_o, .chip_select_a_n_o, .chip_select_b_o, .chip_select_c_n_o,
        .output_enable_n_o, .write_enable_n_o, .data_lines_i, .data_lines_o, .data_lines_oe_o);
    sram_mem_model sram_mem_model_i (.addr_i(mem_addr_o), .sel_a_n_i(chip_select_a_n_o),
        .sel_b_i(chip_select_b_o), .sel_c_n_i(chip_select_c_n_o), .oe_n_i(output_enable_n_o),
        .we_n_i(write_enable_n_o), .bus_i(data_lines_i), .slow_i(slow), .data_o(mem_data),
        .drive_o(mem_drive), .standby_o(standby));
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end
    // one comparison, counted
    task automatic chk(input logic [DATA_WIDTH-1:0] seen, input logic [DATA_WIDTH-1:0] want);
        compares++;
        if (seen !== want)
        begin
            fails++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    // verdict and end of run
    task automatic close_out();
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one request, entered and left at a falling edge
    task automatic op(input logic wr, input logic [ADDR_WIDTH-1:0] a,
        input logic [DATA_WIDTH-1:0] d);
        int n;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 20)
        begin
            @(negedge clk_i);
            n++;
        end
        req_valid_i = 1;
        req_write_i = wr;
        req_addr_i = a;
        req_wdata_i = d;
        @(negedge clk_i);
        req_valid_i = 0;
        if (!wr)
        begin
            n = 0;
            while (rsp_valid_o !== 1'b1 && n < 8)
            begin
                chk({write_enable_n_o, data_lines_oe_o}, 2'b10);
                @(negedge clk_i);
                n++;
            end
            chk(n, READ_WAIT_CYC);
            chk(rsp_rdata_o, d);
        end
    endtask
    // wait for the power-up wait to end, selects a and b must stay off meanwhile
    task automatic powerup();
        int n;
        n = 0;
        while (init_done_o !== 1'b1 && n < 40)
        begin
            chk({chip_select_a_n_o, chip_select_b_o, write_enable_n_o}, 3'b101);
            @(negedge clk_i);
            n++;
            if (n == PU - 3)
                req_valid_i = 0;
        end
        chk(n, PU);
    endtask
    // the bus must never be driven from both ends
    always @(negedge clk_i)
        if (!rst_i)
            chk(data_lines_oe_o & mem_drive, 1'b0);
    // hang guard
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            close_out();
        end
    end
    initial
    begin
        repeat (5) @(negedge clk_i);
        chk({chip_select_a_n_o, chip_select_b_o, chip_select_c_n_o, write_enable_n_o,
            output_enable_n_o, data_lines_oe_o, req_ready_o}, 7'b1011100);
        rst_i = 0;
        // a request offered during the wait is ignored
        req_valid_i = 1;
        req_write_i = 1;
        powerup();
        for (int i = 0; i < 8; i++)
        begin
            slow = (i >= 4);
            op(ROWS[i][41], ROWS[i][40:24], ROWS[i][23:0]);
        end
        // reset in mid-write releases the pins at once
        op(1'b1, 17'h00100, 24'h3C3C3C);
        @(negedge clk_i);
        rst_i = 1;
        #1;
        chk({chip_select_b_o, write_enable_n_o, data_lines_oe_o}, 3'b010);
        @(negedge clk_i);
        rst_i = 0;
        powerup();
        op(1'b0, 17'h1FFFF, 24'h000001);
        // deselected memory must have dropped to standby by now
        repeat (3) @(negedge clk_i);
        chk(standby, 1'b1);
        close_out();
    end
endmodule
